/* File: pkg/lgw_pkg.sv */
// Purpose: Shared constants for the low-power gyro, motion threshold, queue enable and frame-sync registers
// Assumes: 8-bit register port with 8-bit addresses
// Notes:   Sensor record byte k sits at bits [8k+7:8k]
package lgw_pkg;
   localparam int           REG_AW            = 8;
   localparam int           REG_DW            = 8;
   localparam logic [7:0]   ADDR_LP_GYRO_CFG  = 8'h1e;
   localparam logic [7:0]   ADDR_THR_X        = 8'h20;
   localparam logic [7:0]   ADDR_THR_Y        = 8'h21;
   localparam logic [7:0]   ADDR_THR_Z        = 8'h22;
   localparam logic [7:0]   ADDR_QUEUE_EN     = 8'h23;
   localparam logic [7:0]   ADDR_FRAME_SYNC_INPUT_STAT   = 8'h36;
   localparam int           BIT_DUTY_EN       = 7;
   localparam int           AVG_MSB           = 6;
   localparam int           AVG_LSB           = 4;
   localparam int           BIT_GYRO_Q        = 4;
   localparam int           BIT_ACCEL_Q       = 3;
   localparam int           BIT_FRAME_SYNC_INPUT_FLAG    = 7;
   localparam logic [7:0]   MASK_LP_CFG       = 8'hf0;
   localparam logic [7:0]   MASK_QUEUE_EN     = 8'h18;
   localparam logic [7:0]   RST_REG           = 8'h00;
   localparam logic [2:0]   RST_AVG           = 3'h0;
   localparam logic [7:0]   AVG_ONE           = 8'h01;
   localparam int           REC_BYTES         = 14;
   localparam int           REC_W             = REC_BYTES * 8;
   localparam logic [3:0]   SLOT_ACCEL_FIRST  = 4'h0;
   localparam logic [3:0]   SLOT_TEMP_FIRST   = 4'h6;
   localparam logic [3:0]   SLOT_TEMP_LAST    = 4'h7;
   localparam logic [3:0]   SLOT_GYRO_LAST    = 4'hd;
   localparam logic [3:0]   SLOT_STEP         = 4'h1;
   localparam logic [7:0]   CNT_STEP          = 8'h01;
   typedef enum logic {LGW_IDLE, LGW_PUSH} lgw_seq_t;
endpackage : lgw_pkg

/* File: rtl/lgw_pacer.sv */
// Purpose: Divides the filter output rate down to the sample rate
// Assumes: filter_tick is a one-cycle pulse on sys_clk
// Notes:   One sample_tick per (divider + 1) filter ticks
`timescale 1ns/1ns
module lgw_pacer
   import lgw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       filter_tick,
   input  wire logic [7:0] sample_rate_divider,
   output logic            sample_tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } lgw_pacer_state_t;

   lgw_pacer_state_t st;
   lgw_pacer_state_t next_st;

   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (filter_tick) begin
         if (st.cnt >= sample_rate_divider) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + CNT_STEP;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sample_tick = st.tick;

   a_pacer_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      filter_tick && st.cnt >= sample_rate_divider |=> sample_tick && st.cnt == 8'h00)
      else $error("sample tick missing at divider terminal count");
endmodule : lgw_pacer

/* File: rtl/lgw_regs.sv */
// Purpose: Low-power gyro config, motion thresholds, queue enables, frame-sync flag and queue sequencer
// Assumes: Register port pulses reg_wr or reg_rd for one cycle; reg_rdata answers one cycle later
// Notes:   Set of a flag wins over a clear in the same cycle
//
// Notes on behaviour
// - Duty-cycle enable bit 7 turns on low-power gyro operation; resets to zero.
// - Averaging select lives in bits 6 to 4; resets to 000.
// - In low-power mode averaging alone filters; the lowpass select is ignored.
// - Averaging codes 0 to 7 mean 1 to 128 samples, doubling.
// - Three 8-bit motion thresholds, X Y Z, at consecutive addresses.
// - Gyro enable queues temperature then six gyro bytes every sample.
// - Accel enable queues six accel bytes then temperature every sample.
// - With both enabled, accel bytes precede gyro bytes in each record.
// - Frame-sync flag sets whenever a frame-sync event is raised.
// - Reading frame-sync status returns the flag, then clears it.
// - Unused bits of these registers are reserved.
// - Sample rate is filter rate over one plus the 8-bit divider.
// - Enabled frame-sync input raises an event on reaching the chosen level.
// - Per-axis motion events gated by own enables; flags clear when read.
`timescale 1ns/1ns
module lgw_regs
   import lgw_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [REG_AW-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic [REG_DW-1:0] reg_wdata,
   input  wire logic              reg_rd,
   output logic      [REG_DW-1:0] reg_rdata,
   output logic                   reg_rvalid,
   input  wire logic [2:0]        gyro_lowpass_select,
   input  wire logic [7:0]        sample_rate_divider,
   input  wire logic              filter_tick,
   input  wire logic [REC_W-1:0]  sensor_record,
   input  wire logic              frame_sync_input,
   input  wire logic              frame_sync_event_enable,
   input  wire logic              frame_sync_active_level,
   input  wire logic              motion_raw_x,
   input  wire logic              motion_raw_y,
   input  wire logic              motion_raw_z,
   input  wire logic              motion_event_x_enable,
   input  wire logic              motion_event_y_enable,
   input  wire logic              motion_event_z_enable,
   input  wire logic              motion_status_read,
   output logic                   gyro_duty_cycle_enable,
   output logic      [2:0]        gyro_average_select,
   output logic      [7:0]        gyro_average_count,
   output logic      [2:0]        gyro_filter_select,
   output logic                   gyro_use_averaging,
   output logic      [7:0]        motion_threshold_x_value,
   output logic      [7:0]        motion_threshold_y_value,
   output logic      [7:0]        motion_threshold_z_value,
   output logic                   gyro_queue_enable,
   output logic                   accel_queue_enable,
   output logic                   queue_push,
   output logic      [7:0]        queue_byte,
   output logic                   frame_sync_event_flag,
   output logic                   frame_sync_irq,
   output logic                   motion_event_x_flag,
   output logic                   motion_event_y_flag,
   output logic                   motion_event_z_flag
);
   typedef struct packed {
      logic [7:0]       lp_cfg;
      logic [7:0]       thr_x;
      logic [7:0]       thr_y;
      logic [7:0]       thr_z;
      logic [7:0]       q_en;
      logic             fs_flag;
      logic             fs_irq;
      logic             fs_prev;
      logic [2:0]       mot_flag;
      logic [7:0]       avg_cnt;
      logic [2:0]       filt_sel;
      logic             use_avg;
      logic [7:0]       rdata;
      logic             rvalid;
      lgw_seq_t         seq;
      logic [3:0]       slot;
      logic [3:0]       last;
      logic [REC_W-1:0] snap;
      logic             push;
      logic [7:0]       qbyte;
   } lgw_regs_state_t;

   lgw_regs_state_t st;
   lgw_regs_state_t next_st;
   logic            fs_level;
   logic            sample_tick;
   logic            fs_event;
   logic [2:0]      mot_event;

   lgw_sync u_fs_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (frame_sync_input),
      .sync_out (fs_level)
   );

   lgw_pacer u_pacer (
      .sys_clk             (sys_clk),
      .rst_n               (rst_n),
      .filter_tick         (filter_tick),
      .sample_rate_divider (sample_rate_divider),
      .sample_tick         (sample_tick)
   );

   always_comb begin
      next_st        = st;
      next_st.rvalid = 1'b0;
      next_st.push   = 1'b0;
      next_st.fs_prev = fs_level;
      // Active-level bit high means the input is active low
      fs_event  = frame_sync_event_enable && (fs_level != st.fs_prev)
                  && (fs_level == !frame_sync_active_level);
      mot_event = {motion_raw_z && motion_event_z_enable,
                   motion_raw_y && motion_event_y_enable,
                   motion_raw_x && motion_event_x_enable};
      next_st.fs_irq = fs_event;
      // Register writes, reserved bits masked off
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_LP_GYRO_CFG: next_st.lp_cfg = reg_wdata & MASK_LP_CFG;
            ADDR_THR_X:       next_st.thr_x  = reg_wdata;
            ADDR_THR_Y:       next_st.thr_y  = reg_wdata;
            ADDR_THR_Z:       next_st.thr_z  = reg_wdata;
            ADDR_QUEUE_EN:    next_st.q_en   = reg_wdata & MASK_QUEUE_EN;
            default:          next_st.rdata  = st.rdata;
         endcase
      end
      // Register reads
      if (reg_rd) begin
         next_st.rvalid = 1'b1;
         unique case (reg_addr)
            ADDR_LP_GYRO_CFG: next_st.rdata = st.lp_cfg;
            ADDR_THR_X:       next_st.rdata = st.thr_x;
            ADDR_THR_Y:       next_st.rdata = st.thr_y;
            ADDR_THR_Z:       next_st.rdata = st.thr_z;
            ADDR_QUEUE_EN:    next_st.rdata = st.q_en;
            ADDR_FRAME_SYNC_INPUT_STAT: begin
               next_st.rdata                 = RST_REG;
               next_st.rdata[BIT_FRAME_SYNC_INPUT_FLAG] = st.fs_flag;
               next_st.fs_flag               = 1'b0;
            end
            default:          next_st.rdata = RST_REG;
         endcase
      end
      if (fs_event) begin
         next_st.fs_flag = 1'b1;
      end
      if (motion_status_read) begin
         next_st.mot_flag = '0;
      end
      next_st.mot_flag = next_st.mot_flag | mot_event;
      // Low-power filter selection
      next_st.avg_cnt  = AVG_ONE << next_st.lp_cfg[AVG_MSB:AVG_LSB];
      next_st.use_avg  = next_st.lp_cfg[BIT_DUTY_EN];
      next_st.filt_sel = next_st.lp_cfg[BIT_DUTY_EN] ? 3'h0 : gyro_lowpass_select;
      // Queue sequencer: slots 0-5 accel, 6-7 temperature, 8-13 gyro
      unique case (st.seq)
         LGW_IDLE: begin
            if (sample_tick && (st.q_en[BIT_ACCEL_Q] || st.q_en[BIT_GYRO_Q])) begin
               next_st.seq  = LGW_PUSH;
               next_st.snap = sensor_record;
               next_st.slot = st.q_en[BIT_ACCEL_Q] ? SLOT_ACCEL_FIRST : SLOT_TEMP_FIRST;
               next_st.last = st.q_en[BIT_GYRO_Q] ? SLOT_GYRO_LAST : SLOT_TEMP_LAST;
            end
         end
         LGW_PUSH: begin
            next_st.push  = 1'b1;
            next_st.qbyte = st.snap[{st.slot, 3'h0} +: 8];
            if (st.slot == st.last) begin
               next_st.seq = LGW_IDLE;
            end else begin
               next_st.slot = st.slot + SLOT_STEP;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st          <= '0;
         st.seq      <= LGW_IDLE;
         st.lp_cfg   <= RST_REG;
         st.avg_cnt  <= AVG_ONE;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata                = st.rdata;
   assign reg_rvalid               = st.rvalid;
   assign gyro_duty_cycle_enable   = st.lp_cfg[BIT_DUTY_EN];
   assign gyro_average_select      = st.lp_cfg[AVG_MSB:AVG_LSB];
   assign gyro_average_count       = st.avg_cnt;
   assign gyro_filter_select       = st.filt_sel;
   assign gyro_use_averaging       = st.use_avg;
   assign motion_threshold_x_value = st.thr_x;
   assign motion_threshold_y_value = st.thr_y;
   assign motion_threshold_z_value = st.thr_z;
   assign gyro_queue_enable        = st.q_en[BIT_GYRO_Q];
   assign accel_queue_enable       = st.q_en[BIT_ACCEL_Q];
   assign queue_push               = st.push;
   assign queue_byte               = st.qbyte;
   assign frame_sync_event_flag    = st.fs_flag;
   assign frame_sync_irq           = st.fs_irq;
   assign motion_event_x_flag      = st.mot_flag[0];
   assign motion_event_y_flag      = st.mot_flag[1];
   assign motion_event_z_flag      = st.mot_flag[2];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_duty_bit_write: assert property (
      reg_wr && reg_addr == ADDR_LP_GYRO_CFG |=> gyro_duty_cycle_enable == $past(reg_wdata[BIT_DUTY_EN]))
      else $error("duty-cycle enable did not take written value");
   a_avg_field_write: assert property (
      reg_wr && reg_addr == ADDR_LP_GYRO_CFG |=> gyro_average_select == $past(reg_wdata[AVG_MSB:AVG_LSB]))
      else $error("averaging select did not take written value");
   a_avg_count_map: assert property (
      $changed(gyro_average_select) |-> gyro_average_count == (8'h01 << gyro_average_select))
      else $error("averaging count does not match select");
   a_lp_filter_use: assert property (
      gyro_duty_cycle_enable |-> gyro_use_averaging && gyro_filter_select == 3'h0)
      else $error("lowpass select leaked into low-power filtering");
   a_threshold_hold: assert property (
      reg_wr && reg_addr == ADDR_THR_Y |=> motion_threshold_y_value == $past(reg_wdata)
      ##1 (reg_wr && reg_addr == ADDR_THR_Y || motion_threshold_y_value == $past(motion_threshold_y_value)))
      else $error("Y threshold not stored or not held");
   a_reserved_read: assert property (
      reg_rd && reg_addr == ADDR_QUEUE_EN |=> reg_rvalid && (reg_rdata & ~MASK_QUEUE_EN) == 8'h00)
      else $error("reserved queue-enable bits read nonzero");
   a_frame_sync_input_sets: assert property (
      fs_event |=> frame_sync_event_flag && frame_sync_irq)
      else $error("frame-sync event did not set flag");
   a_frame_sync_input_rdclr: assert property (
      reg_rd && reg_addr == ADDR_FRAME_SYNC_INPUT_STAT && !fs_event
      |=> !frame_sync_event_flag && reg_rdata[BIT_FRAME_SYNC_INPUT_FLAG] == $past(frame_sync_event_flag))
      else $error("frame-sync read did not return then clear flag");
   a_frame_sync_input_gate: assert property (
      !frame_sync_event_enable |=> !frame_sync_irq)
      else $error("frame-sync event raised while disabled");
   a_accel_first: assert property (
      st.seq == LGW_IDLE && sample_tick && accel_queue_enable
      |=> ##1 queue_push && queue_byte == $past(sensor_record[7:0], 2))
      else $error("record did not open with accel X high byte");
   a_gyro_only: assert property (
      st.seq == LGW_IDLE && sample_tick && gyro_queue_enable && !accel_queue_enable
      |=> ##1 queue_push && queue_byte == $past(sensor_record[55:48], 2))
      else $error("gyro-only record did not open with temperature");
   a_motion_gate: assert property (
      !motion_event_x_enable && !motion_event_x_flag |=> !motion_event_x_flag)
      else $error("disabled X motion event set its flag");

   a_thr_x_write: assert property (
      reg_wr && reg_addr == ADDR_THR_X |=> motion_threshold_x_value == $past(reg_wdata))
      else $error("X threshold did not take written value");
   a_thr_z_write: assert property (
      reg_wr && reg_addr == ADDR_THR_Z |=> motion_threshold_z_value == $past(reg_wdata))
      else $error("Z threshold did not take written value");
   a_queue_en_write: assert property (
      reg_wr && reg_addr == ADDR_QUEUE_EN
      |=> gyro_queue_enable == $past(reg_wdata[BIT_GYRO_Q]) && accel_queue_enable == $past(reg_wdata[BIT_ACCEL_Q]))
      else $error("queue enables did not take written value");

   a_lp_reserved_read: assert property (
      reg_rd && reg_addr == ADDR_LP_GYRO_CFG |=> reg_rvalid && (reg_rdata & ~MASK_LP_CFG) == RST_REG)
      else $error("reserved low-power config bits read nonzero");
   a_frame_sync_input_reserved: assert property (
      reg_rd && reg_addr == ADDR_FRAME_SYNC_INPUT_STAT |=> reg_rvalid && reg_rdata[BIT_FRAME_SYNC_INPUT_FLAG-1:0] == '0)
      else $error("reserved frame-sync status bits read nonzero");
   a_rvalid_pulse: assert property (
      $past(rst_n) |-> reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after read strobe");

   a_avg_count_all: assert property (
      gyro_average_count == (AVG_ONE << gyro_average_select))
      else $error("averaging count wrong for current select");
   a_lp_use_off: assert property (
      $past(rst_n) && !gyro_duty_cycle_enable
      |-> !gyro_use_averaging && gyro_filter_select == $past(gyro_lowpass_select))
      else $error("lowpass select not passed through outside low-power mode");

   a_irq_one_cycle: assert property (
      frame_sync_irq |=> !frame_sync_irq)
      else $error("frame-sync event pulse longer than one cycle");
   a_motion_set: assert property (
      mot_event[0] |=> motion_event_x_flag)
      else $error("enabled X motion event did not set its flag");
   a_motion_clear: assert property (
      motion_status_read && !mot_event[0] |=> !motion_event_x_flag)
      else $error("X motion flag not cleared by status read");

   a_queue_idle: assert property (
      st.seq == LGW_IDLE && !accel_queue_enable && !gyro_queue_enable |=> !queue_push)
      else $error("byte queued with both queue enables off");
   a_accel_only_end: assert property (
      st.seq == LGW_IDLE && sample_tick && accel_queue_enable && !gyro_queue_enable
      |=> ##8 queue_push && queue_byte == $past(sensor_record[{SLOT_TEMP_LAST, 3'h0} +: 8], 9) ##1 !queue_push)
      else $error("accel-only record did not end with temperature low byte");
   a_gyro_after_accel: assert property (
      st.seq == LGW_IDLE && sample_tick && accel_queue_enable && gyro_queue_enable
      |=> ##14 queue_push && queue_byte == $past(sensor_record[REC_W-1 -: 8], 15) ##1 !queue_push)
      else $error("combined record did not end with last gyro byte");
endmodule : lgw_regs

/* File: rtl/lgw_sync.sv */
// Purpose: Three-stage synchroniser for a level arriving from a pin
// Assumes: Input is asynchronous to sys_clk
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ns
module lgw_sync
   import lgw_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } lgw_sync_state_t;

   lgw_sync_state_t st;
   lgw_sync_state_t next_st;

   always_comb begin
      next_st     = st;
      next_st.s1  = async_in;
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.lvl;
endmodule : lgw_sync

/* File: test/lgw_host.sv */
// Purpose: Host model that drives the register port of the config block
// Assumes: Strobes last one cycle and are launched at the falling edge
// Notes:   Idle address and data lines show the inverse of the last value
`timescale 1ns/1ns
module lgw_host
(
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // One write or read strobe, held across one sampling edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = w;
      reg_rd    = !w;
      @(negedge sys_clk);
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : xfer
endmodule : lgw_host

/* File: test/test_lp_gyro_wom_fifo_cfg_regs.sv */
// Purpose: Self-checking bench for the low-power gyro and queue config registers
// Assumes: Inputs change at the falling edge; results are watched at the rising edge
// Notes:   Expected reads and queue bytes wait in queues until the outputs show them
`timescale 1ns/1ns
module test_lp_gyro_wom_fifo_cfg_regs;
   import lgw_pkg::*;
   logic             sys_clk, rst_n, filter_tick, frame_sync_input, frame_sync_event_enable;
   logic             frame_sync_active_level, motion_status_read, reg_wr, reg_rd, reg_rvalid;
   logic             gyro_duty_cycle_enable, gyro_use_averaging, gyro_queue_enable, accel_queue_enable;
   logic             queue_push, frame_sync_event_flag, frame_sync_irq;
   logic [2:0]       gyro_lowpass_select, gyro_average_select, gyro_filter_select, raw, men;
   wire  [2:0]       mflag;
   logic [7:0]       reg_addr, reg_wdata, reg_rdata, sample_rate_divider, gyro_average_count, queue_byte;
   wire  [7:0]       thr[3];
   logic [7:0]       v[3];
   logic [REC_W-1:0] sensor_record;
   logic [7:0]       rd_q[$];
   logic [7:0]       byte_q[$];
   int               mismatches, num_checks, cycles, irq_seen;

   lgw_regs uut (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
      .gyro_lowpass_select, .sample_rate_divider, .filter_tick, .sensor_record, .frame_sync_input,
      .frame_sync_event_enable, .frame_sync_active_level, .motion_raw_x(raw[0]), .motion_raw_y(raw[1]),
      .motion_raw_z(raw[2]), .motion_event_x_enable(men[0]), .motion_event_y_enable(men[1]),
      .motion_event_z_enable(men[2]), .motion_status_read, .gyro_duty_cycle_enable, .gyro_average_select,
      .gyro_average_count, .gyro_filter_select, .gyro_use_averaging, .motion_threshold_x_value(thr[0]),
      .motion_threshold_y_value(thr[1]), .motion_threshold_z_value(thr[2]), .gyro_queue_enable,
      .accel_queue_enable, .queue_push, .queue_byte, .frame_sync_event_flag, .frame_sync_irq,
      .motion_event_x_flag(mflag[0]), .motion_event_y_flag(mflag[1]), .motion_event_z_flag(mflag[2]));
   lgw_host host (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic give_verdict();
      if (mismatches == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask : rd

   task automatic tick();
      @(negedge sys_clk);
      filter_tick = 1'b1;
      @(negedge sys_clk);
      filter_tick = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask : tick

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Watches answers and takes the oldest expectation off its queue
   always @(posedge sys_clk) begin
      if (frame_sync_irq === 1'b1) irq_seen++;
      if (reg_rvalid === 1'b1) chk("read data", rd_q.size() ? rd_q.pop_front() : 8'hxx, reg_rdata);
      if (queue_push === 1'b1) chk("queue byte", byte_q.size() ? byte_q.pop_front() : 8'hxx, queue_byte);
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      rst_n = 1'b0;
      filter_tick = 1'b0;
      frame_sync_input = 1'b0;
      frame_sync_event_enable = 1'b0;
      frame_sync_active_level = 1'b0;
      motion_status_read = 1'b0;
      gyro_lowpass_select = 3'h0;
      sample_rate_divider = 8'h00;
      sensor_record = '0;
      raw = 3'h0;
      men = 3'h0;
      void'($urandom(32'h4059a647));
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      chk("average count", AVG_ONE, gyro_average_count);
      foreach (thr[i]) rd(ADDR_THR_X + 8'(i), 8'h00);
      rd(ADDR_LP_GYRO_CFG, 8'h00);
      rd(ADDR_QUEUE_EN, 8'h00);
      rd(ADDR_FRAME_SYNC_INPUT_STAT, 8'h00);
      for (int c = 0; c < 8; c++) begin
         gyro_lowpass_select = 3'($urandom);
         wr(ADDR_LP_GYRO_CFG, {1'b1, 3'(c), 4'hf});
         chk("duty enable", 8'h01, 8'(gyro_duty_cycle_enable));
         chk("average select", 8'(c), 8'(gyro_average_select));
         chk("average count", 8'h01 << c, gyro_average_count);
         rd(ADDR_LP_GYRO_CFG, {1'b1, 3'(c), 4'h0});
         chk("filter select", 8'h00, 8'(gyro_filter_select));
         chk("use averaging", 8'h01, 8'(gyro_use_averaging));
      end
      wr(ADDR_LP_GYRO_CFG, 8'h0f);
      repeat (2) @(negedge sys_clk);
      chk("filter select", 8'(gyro_lowpass_select), 8'(gyro_filter_select));
      rd(ADDR_LP_GYRO_CFG, 8'h00);
      foreach (v[i]) begin
         v[i] = 8'($urandom);
         wr(ADDR_THR_X + 8'(i), v[i]);
      end
      wr(8'h1f, 8'hff);
      foreach (v[i]) begin
         rd(ADDR_THR_X + 8'(i), v[i]);
         chk("threshold", v[i], thr[i]);
      end
      rd(8'h1f, 8'h00);
      for (int m = 0; m < 4; m++) begin
         sample_rate_divider = 8'(m);
         sensor_record = REC_W'({$urandom, $urandom, $urandom, $urandom});
         wr(ADDR_QUEUE_EN, {3'h7, m[1], m[0], 3'h7});
         rd(ADDR_QUEUE_EN, {3'h0, m[1], m[0], 3'h0});
         chk("queue enables", 8'(m), {6'h0, gyro_queue_enable, accel_queue_enable});
         repeat (m) tick();
         for (int k = (m[0] ? 0 : 6); k <= (m[1] ? 13 : 7); k++)
            if (m != 0) byte_q.push_back(sensor_record[8*k +: 8]);
         tick();
         repeat (20) @(negedge sys_clk);
         chk("bytes left", 8'h00, 8'(byte_q.size()));
      end
      for (int j = 0; j < 4; j++) begin
         frame_sync_event_enable = 1'b0;
         frame_sync_active_level = j[0];
         frame_sync_input = j[0];
         repeat (8) @(negedge sys_clk);
         frame_sync_event_enable = j[1];
         irq_seen = 0;
         frame_sync_input = !j[0];
         repeat (10) @(negedge sys_clk);
         chk("irq pulses", 8'(j[1]), 8'(irq_seen));
         chk("sync flag", 8'(j[1]), 8'(frame_sync_event_flag));
         rd(ADDR_FRAME_SYNC_INPUT_STAT, {j[1], 7'h0});
         rd(ADDR_FRAME_SYNC_INPUT_STAT, 8'h00);
      end
      for (int j = 0; j < 6; j++) begin
         men = j[0] ? 3'h7 : ~3'(1 << (j >> 1));
         raw = 3'(1 << (j >> 1));
         @(negedge sys_clk);
         raw = 3'h0;
         @(negedge sys_clk);
         chk("motion flags", 8'(men & 3'(1 << (j >> 1))), 8'(mflag));
         motion_status_read = 1'b1;
         @(negedge sys_clk);
         motion_status_read = 1'b0;
         @(negedge sys_clk);
         chk("motion flags", 8'h00, 8'(mflag));
      end
      repeat (3) @(negedge sys_clk);
      chk("reads left", 8'h00, 8'(rd_q.size()));
      give_verdict();
   end
endmodule : test_lp_gyro_wom_fifo_cfg_regs
